// >>> logic/rtcm_regs.sv
`default_nettype none
module rtcm_regs #(
    parameter longint TICK_CYC = rtcm_pkg::TICK_CYC,
    parameter longint SNAP_LOW_CYC = rtcm_pkg::SNAP_LOW_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Asynchronous memory bus
    input wire logic [rtcm_pkg::ADDR_W-1:0] ADDR,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic [7:0] DQ_IN,
    output logic [7:0] DQ_OUT,
    output logic DQ_OE_N,
    // Status sources from neighbouring logic
    input wire logic CELL_LOW,
    input wire logic ALARM_HIT,
    input wire logic WDOG_HIT
);
    localparam int DIV_W = $clog2(TICK_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);

    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lim, input logic [7:0] lo);
        return (v >= lim) ? {1'b1, lo} : (v[3:0] >= 4'h9) ? {1'b0, v[7:4] + 4'h1, 4'h0}
            : {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
        return (old & ~m) | (nw & m);
    endfunction

    // Last date of a month, leap years by BCD year
    function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        return (mon == 8'h02) ? (leap ? 8'h29 : 8'h28)
            : (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) ? 8'h30 : 8'h31;
    endfunction

    rtcm_pkg::rtcm_bus_e bus_st_q;
    logic [rtcm_pkg::ADDR_W-1:0] acc_addr_q;
    logic [7:0] wr_data_q;
    logic [7:0] int_q [rtcm_pkg::TK_N];
    logic [7:0] ext_q [rtcm_pkg::TK_N];
    logic [7:0] inc_d [rtcm_pkg::TK_N];
    logic [7:0] misc_q [1:7];
    logic load_q;
    logic snap_q;
    logic halt_q;
    logic wdog_flag_q;
    logic alarm_flag_q;
    logic [DIV_W-1:0] div_q;
    logic tick_q;
    logic wr_now;
    logic rd_now;
    logic commit;
    logic rd_end;
    logic page_hit;
    logic [3:0] idx;
    logic [2:0] tki;
    logic tk_wr;
    logic ext_wr;
    logic int_wr;
    logic xfer;
    logic [7:0] rd_byte;
    logic flag_clr;

    assign wr_now = !CE_N && !WE_N;
    assign rd_now = !CE_N && WE_N;
    assign commit = (bus_st_q == rtcm_pkg::BUS_WRITE) && !wr_now;
    assign rd_end = (bus_st_q == rtcm_pkg::BUS_READ) && !rd_now;
    assign page_hit = acc_addr_q[12:4] == rtcm_pkg::REG_PAGE;
    assign idx = acc_addr_q[3:0];
    assign tki = idx[2:0];
    assign tk_wr = commit && page_hit && idx[3];
    // Writes under load hold land in the visible copy only, except the load-clearing century write, which also reaches the internal copy
    assign ext_wr = tk_wr && (load_q || (tki == 3'(rtcm_pkg::I_CENT) && wr_data_q[rtcm_pkg::CTL_LOAD_BIT]));
    assign int_wr = tk_wr && !ext_wr && !load_q;
    assign xfer = tk_wr && load_q && tki == 3'(rtcm_pkg::I_CENT) && !wr_data_q[rtcm_pkg::CTL_LOAD_BIT];
    assign flag_clr = (commit || rd_end) && page_hit && idx == rtcm_pkg::OFF_FLAGS[3:0];

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            bus_st_q <= rtcm_pkg::BUS_IDLE;
            acc_addr_q <= 13'h0000;
            wr_data_q <= 8'h00;
        end
        else
        begin
            bus_st_q <= wr_now ? rtcm_pkg::BUS_WRITE : (rd_now ? rtcm_pkg::BUS_READ : rtcm_pkg::BUS_IDLE);
            if (!CE_N)
            begin
                acc_addr_q <= ADDR;
            end
            // Data taken on the last cycle of the write
            if (wr_now)
            begin
                wr_data_q <= DQ_IN;
            end
        end
    end

    // Seconds prescaler, cleared to zero while the oscillator is stopped
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            div_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            div_q <= (halt_q || xfer || div_q == DIV_LAST) ? '0 : div_q + 1'b1;
            tick_q <= !halt_q && !xfer && div_q == DIV_LAST;
        end
    end

    // Next calendar value, carry rippling up the chain
    always_comb
    begin
        logic [8:0] s;
        logic [8:0] d;
        logic [7:0] v;
        s = 9'h000;
        d = 9'h000;
        v = 8'h00;
        inc_d = int_q;
        for (int i = rtcm_pkg::I_SEC; i <= rtcm_pkg::I_WDAY; i++)
        begin
            if (i == rtcm_pkg::I_SEC || s[8])
            begin
                v = int_q[i] & rtcm_pkg::TK_MASK[i];
                s = bcd_step(v, rtcm_pkg::TK_MAX[i], rtcm_pkg::TK_LO[i]);
                inc_d[i] = merge(int_q[i], s[7:0], rtcm_pkg::TK_MASK[i]);
                d[8] = (i == rtcm_pkg::I_HR) ? s[8] : d[8];
            end
        end
        for (int i = rtcm_pkg::I_DATE; i <= rtcm_pkg::I_YEAR + 1; i++)
        begin
            if (d[8])
            begin
                v = int_q[i % rtcm_pkg::TK_N] & rtcm_pkg::TK_MASK[i % rtcm_pkg::TK_N];
                if (i == rtcm_pkg::I_DATE)
                begin
                    d = bcd_step(v, month_end(int_q[rtcm_pkg::I_MON] & rtcm_pkg::TK_MASK[rtcm_pkg::I_MON],
                        int_q[rtcm_pkg::I_YEAR]), rtcm_pkg::TK_LO[i]);
                end
                else
                begin
                    d = bcd_step(v, rtcm_pkg::TK_MAX[i % rtcm_pkg::TK_N], rtcm_pkg::TK_LO[i % rtcm_pkg::TK_N]);
                end
                inc_d[i % rtcm_pkg::TK_N] = merge(int_q[i % rtcm_pkg::TK_N], d[7:0],
                    rtcm_pkg::TK_MASK[i % rtcm_pkg::TK_N]);
            end
        end
    end

    // Internal running copy
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            int_q <= rtcm_pkg::TK_RST;
        end
        else if (xfer)
        begin
            int_q <= ext_q;
            int_q[rtcm_pkg::I_CENT] <= {2'b00, wr_data_q[5:0]};
        end
        else
        begin
            if (tick_q)
            begin
                int_q <= inc_d;
            end
            // Write lands on top of the tick, so no second is lost
            if (int_wr)
            begin
                int_q[tki] <= (tki == 3'(rtcm_pkg::I_CENT)) ? {2'b00, wr_data_q[5:0]} : wr_data_q;
            end
        end
    end

    // Visible copy follows unless frozen or loading
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ext_q <= rtcm_pkg::TK_RST;
        end
        else
        begin
            if (!snap_q && !load_q)
            begin
                ext_q <= int_q;
            end
            if (ext_wr)
            begin
                ext_q[tki] <= (tki == 3'(rtcm_pkg::I_CENT)) ? {2'b00, wr_data_q[5:0]} : wr_data_q;
            end
        end
    end

    // Hold bits and oscillator stop
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            load_q <= 1'b0;
            snap_q <= 1'b0;
            halt_q <= 1'b1;
        end
        else if (tk_wr && tki == 3'(rtcm_pkg::I_CENT))
        begin
            load_q <= wr_data_q[rtcm_pkg::CTL_LOAD_BIT];
            snap_q <= wr_data_q[rtcm_pkg::CTL_SNAP_BIT];
        end
        else if (tk_wr && tki == 3'(rtcm_pkg::I_SEC))
        begin
            halt_q <= wr_data_q[rtcm_pkg::SEC_HALT_BIT];
        end
    end

    // Alarm, interrupt, watchdog and spare storage, outside hold control
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            misc_q <= '{default: rtcm_pkg::MISC_RST};
        end
        else if (commit && page_hit && !idx[3] && idx[2:0] != 3'h0)
        begin
            misc_q[idx[2:0]] <= wr_data_q;
        end
    end

    // Sticky flags cleared by a flags access; a new event wins
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            wdog_flag_q <= 1'b0;
            alarm_flag_q <= 1'b0;
        end
        else
        begin
            wdog_flag_q <= WDOG_HIT || (wdog_flag_q && !flag_clr);
            alarm_flag_q <= ALARM_HIT || (alarm_flag_q && !flag_clr);
        end
    end

    always_comb
    begin
        rd_byte = 8'h00;
        if (ADDR[12:4] == rtcm_pkg::REG_PAGE)
        begin
            if (ADDR[3:0] == rtcm_pkg::OFF_FLAGS[3:0])
            begin
                rd_byte[rtcm_pkg::FLG_WDOG_BIT] = wdog_flag_q;
                rd_byte[rtcm_pkg::FLG_ALARM_BIT] = alarm_flag_q;
                rd_byte[rtcm_pkg::FLG_CELL_BIT] = CELL_LOW;
            end
            else if (!ADDR[3])
            begin
                rd_byte = misc_q[ADDR[2:0]];
            end
            else if (ADDR[2:0] == 3'(rtcm_pkg::I_CENT))
            begin
                rd_byte = {load_q, snap_q, ext_q[rtcm_pkg::I_CENT][5:0]};
            end
            else if (ADDR[2:0] == 3'(rtcm_pkg::I_SEC))
            begin
                rd_byte = {halt_q, ext_q[rtcm_pkg::I_SEC][6:0]};
            end
            else
            begin
                rd_byte = ext_q[ADDR[2:0]];
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            DQ_OUT <= 8'h00;
            DQ_OE_N <= 1'b1;
        end
        else
        begin
            DQ_OUT <= rd_now ? rd_byte : 8'h00;
            DQ_OE_N <= !(rd_now && !OE_N);
        end
    end

    // Power-up clearing of the frequency test bit is the reset value of the weekday byte
    logic [31:0] snap_low_cnt;
    always_ff @(posedge CLK)
    begin
        if (!RSTN || snap_q || load_q)
        begin
            snap_low_cnt <= 32'h0;
        end
        else if (snap_low_cnt < 32'(SNAP_LOW_CYC))
        begin
            snap_low_cnt <= snap_low_cnt + 32'h1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    property p_flags_zero;
        rd_now && ADDR == rtcm_pkg::OFF_FLAGS |=> (DQ_OUT & rtcm_pkg::FLG_ZERO_MASK) == 8'h00;
    endproperty
    a_flags_zero: assert property (p_flags_zero) else $error("flags reserved bits not zero");

    property p_cell_ro;
        rd_now && ADDR == rtcm_pkg::OFF_FLAGS |=> DQ_OUT[rtcm_pkg::FLG_CELL_BIT] == $past(CELL_LOW);
    endproperty
    a_cell_ro: assert property (p_cell_ro) else $error("cell low flag not from monitor");

    property p_freeze;
        snap_q && !load_q && !ext_wr ##1 snap_q |-> $stable(ext_q[rtcm_pkg::I_SEC]) && $stable(ext_q[rtcm_pkg::I_MIN]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("visible copy moved while frozen");

    property p_refresh;
        !snap_q && !load_q && !ext_wr |=> ext_q[rtcm_pkg::I_SEC] == $past(int_q[rtcm_pkg::I_SEC]);
    endproperty
    a_refresh: assert property (p_refresh) else $error("visible copy not refreshed");

    property p_count;
        tick_q && !xfer && !int_wr |=> int_q[rtcm_pkg::I_SEC] != $past(int_q[rtcm_pkg::I_SEC]);
    endproperty
    a_count: assert property (p_count) else $error("seconds did not advance on tick");

    property p_halt;
        halt_q ##1 halt_q |-> !tick_q;
    endproperty
    a_halt: assert property (p_halt) else $error("tick while oscillator stopped");

    property p_xfer;
        xfer |=> int_q[rtcm_pkg::I_HR] == $past(ext_q[rtcm_pkg::I_HR]) && !load_q;
    endproperty
    a_xfer: assert property (p_xfer) else $error("load transfer missing");

    property p_load_protect;
        load_q && tk_wr && tki == 3'(rtcm_pkg::I_MIN) && !tick_q |=> $stable(int_q[rtcm_pkg::I_MIN]);
    endproperty
    a_load_protect: assert property (p_load_protect) else $error("load write reached counters");

    property p_read_drive;
        rd_now && !OE_N |=> !DQ_OE_N ##1 (DQ_OE_N == !($past(rd_now) && !$past(OE_N)));
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");

    c_tick: cover property (tick_q && !halt_q);
    c_xfer: cover property (xfer);
    c_frozen_tick: cover property (snap_q && tick_q);
    c_snap_low: cover property (snap_low_cnt == 32'(SNAP_LOW_CYC) && ext_q[rtcm_pkg::I_SEC] == int_q[rtcm_pkg::I_SEC]);
endmodule
`default_nettype wire

// >>> pkg/rtcm_pkg.sv
`default_nettype none
package rtcm_pkg;
    localparam int ADDR_W = 13;
    localparam logic [8:0] REG_PAGE = 9'h1ff;
    localparam logic [12:0] OFF_FLAGS = 13'h1ff0;
    localparam logic [12:0] OFF_SPARE = 13'h1ff1;
    localparam logic [12:0] OFF_ALM_SEC = 13'h1ff2;
    localparam logic [12:0] OFF_ALM_MIN = 13'h1ff3;
    localparam logic [12:0] OFF_ALM_HR = 13'h1ff4;
    localparam logic [12:0] OFF_ALM_DATE = 13'h1ff5;
    localparam logic [12:0] OFF_IRQ_EN = 13'h1ff6;
    localparam logic [12:0] OFF_WDOG = 13'h1ff7;
    localparam logic [12:0] OFF_CTRL = 13'h1ff8;
    localparam logic [12:0] OFF_SEC = 13'h1ff9;
    localparam logic [12:0] OFF_MIN = 13'h1ffa;
    localparam logic [12:0] OFF_HR = 13'h1ffb;
    localparam logic [12:0] OFF_WDAY = 13'h1ffc;
    localparam logic [12:0] OFF_DATE = 13'h1ffd;
    localparam logic [12:0] OFF_MON = 13'h1ffe;
    localparam logic [12:0] OFF_YEAR = 13'h1fff;
    // Timekeeping byte index: 0 century .. 7 year
    localparam int TK_N = 8;
    localparam int I_CENT = 0;
    localparam int I_SEC = 1;
    localparam int I_MIN = 2;
    localparam int I_HR = 3;
    localparam int I_WDAY = 4;
    localparam int I_DATE = 5;
    localparam int I_MON = 6;
    localparam int I_YEAR = 7;
    localparam int CTL_LOAD_BIT = 7;
    localparam int CTL_SNAP_BIT = 6;
    localparam int SEC_HALT_BIT = 7;
    localparam int DAY_FT_BIT = 6;
    localparam int WD_STEER_BIT = 7;
    localparam int IE_ALARM_BIT = 7;
    localparam int IE_BACKUP_BIT = 5;
    localparam int ALM_MASK_BIT = 7;
    localparam int FLG_WDOG_BIT = 7;
    localparam int FLG_ALARM_BIT = 6;
    localparam int FLG_CELL_BIT = 4;
    localparam logic [7:0] FLG_ZERO_MASK = 8'h2f;
    localparam logic [7:0] TK_MASK [TK_N] = '{8'h3f, 8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff};
    localparam logic [7:0] TK_MAX [TK_N] = '{8'h39, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
    localparam logic [7:0] TK_LO [TK_N] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0] TK_RST [TK_N] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam longint CLK_HZ = 40_000_000;
    localparam longint TICK_PERIOD_S = 1;
    localparam longint TICK_CYC = CLK_HZ * TICK_PERIOD_S;
    localparam longint SNAP_LOW_US = 500;
    localparam longint SNAP_LOW_CYC = (CLK_HZ / 1_000_000) * SNAP_LOW_US;
    typedef enum logic [2:0] {BUS_IDLE = 3'b001, BUS_READ = 3'b010, BUS_WRITE = 3'b100} rtcm_bus_e;
endpackage
`default_nettype wire

// >>> sim/rtcm_host.sv
`default_nettype none
module rtcm_host (
    // Clock
    input wire logic CLK,
    // Bus toward the device
    output logic [rtcm_pkg::ADDR_W-1:0] ADDR,
    output logic CE_N,
    output logic OE_N,
    output logic WE_N,
    output logic [7:0] DQ_IN
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        ADDR = '0;
        CE_N = 1'b1;
        OE_N = 1'b1;
        WE_N = 1'b1;
        DQ_IN = 8'h00;
    end

    // Byte write; extra stretches the strobe for a slow host
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input int extra);
        @(posedge CLK);
        #2;
        ADDR = a;
        DQ_IN = d;
        CE_N = 1'b0;
        WE_N = 1'b0;
        repeat (extra) @(posedge CLK);
        @(posedge CLK);
        #2;
        CE_N = 1'b1;
        WE_N = 1'b1;
        DQ_IN = ~d;
        @(posedge CLK);
    endtask

    // Byte read of one cycle; oe high leaves the data lines undriven
    task automatic rd(input logic [12:0] a, input logic oe);
        @(posedge CLK);
        #2;
        ADDR = a;
        CE_N = 1'b0;
        WE_N = 1'b1;
        OE_N = oe;
        @(posedge CLK);
        #2;
        CE_N = 1'b1;
        OE_N = 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> sim/rtcm_regs_bench.sv
`default_nettype none
module rtcm_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint TICKS = 16;
    logic clk = 1'b0;
    logic rstn, cell_low, alarm_hit, wdog_hit, ce_n, oe_n, we_n, dq_oe_n;
    logic [12:0] addr;
    logic [7:0] dq_in, dq_out;
    logic [7:0] exp_q [$];
    logic [31:0] seed;
    int mismatches = 0;
    int cmp_count = 0;
    localparam logic [12:0] RST_A [7] = '{13'h1ff8, 13'h1ff9, 13'h1ffc, 13'h1ffd, 13'h1ffe, 13'h1ff0, 13'h0123};
    localparam logic [7:0] RST_V [7] = '{8'h00, 8'h80, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    localparam logic [7:0] SET_V [7] = '{8'h59, 8'h59, 8'h23, 8'h47, 8'h28, 8'h82, 8'h99};
    localparam logic [7:0] ROLL_V [7] = '{8'h00, 8'h00, 8'h00, 8'h41, 8'h01, 8'h83, 8'h99};

    always #12.5 clk = ~clk;

    rtcm_regs #(.TICK_CYC(TICKS), .SNAP_LOW_CYC(8)) i_rtcm_regs (
        .CLK(clk), .RSTN(rstn), .ADDR(addr), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
        .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n),
        .CELL_LOW(cell_low), .ALARM_HIT(alarm_hit), .WDOG_HIT(wdog_hit)
    );

    rtcm_host i_rtcm_host (
        .CLK(clk), .ADDR(addr), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .DQ_IN(dq_in)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Note the expected byte, then let the host read it
    task automatic rx(input logic [12:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_rtcm_host.rd(a, 1'b0);
    endtask

    task automatic pulse(input int which);
        @(posedge clk);
        #2;
        if (which == 0) alarm_hit = 1'b1;
        else wdog_hit = 1'b1;
        @(posedge clk);
        #2;
        alarm_hit = 1'b0;
        wdog_hit = 1'b0;
    endtask

    // Every driven read result is matched against the oldest note
    always @(posedge clk)
    begin
        if (rstn === 1'b1 && dq_oe_n === 1'b0)
        begin
            if (exp_q.size() == 0)
                check(dq_out, ~dq_out);
            else
                check(dq_out, exp_q.pop_front());
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        rstn = 1'b0;
        cell_low = 1'b0;
        alarm_hit = 1'b0;
        wdog_hit = 1'b0;
        seed = 32'd37964;
        repeat (5) @(posedge clk);
        #2;
        rstn = 1'b1;
        foreach (RST_A[i]) rx(RST_A[i], RST_V[i]);
        $display("test power_up done");
        for (int i = 1; i < 8; i++)
        begin
            seed = xs(seed);
            i_rtcm_host.wr(13'h1ff0 + 13'(i), seed[7:0], i % 2);
            rx(13'h1ff0 + 13'(i), seed[7:0]);
        end
        $display("test storage done");
        cell_low = 1'b1;
        i_rtcm_host.wr(13'h1ff0, 8'hff, 0);
        rx(13'h1ff0, 8'h10);
        pulse(0);
        rx(13'h1ff0, 8'h50);
        rx(13'h1ff0, 8'h10);
        pulse(1);
        rx(13'h1ff0, 8'h90);
        cell_low = 1'b0;
        i_rtcm_host.rd(13'h1ff1, 1'b1);
        $display("test flags done");
        i_rtcm_host.wr(13'h1ff8, 8'h80, 0);
        foreach (SET_V[i]) i_rtcm_host.wr(13'h1ff9 + 13'(i), SET_V[i], 0);
        repeat (40) @(posedge clk);
        rx(13'h1ff9, 8'h59);
        i_rtcm_host.wr(13'h1ff8, 8'h39, 0);
        repeat (20) @(posedge clk);
        i_rtcm_host.wr(13'h1ff8, 8'h79, 0);
        rx(13'h1ff8, 8'h79);
        foreach (ROLL_V[i]) rx(13'h1ff9 + 13'(i), ROLL_V[i]);
        i_rtcm_host.wr(13'h1ff1, 8'h5a, 0);
        rx(13'h1ff1, 8'h5a);
        repeat (37) @(posedge clk);
        rx(13'h1ff9, 8'h00);
        i_rtcm_host.wr(13'h1ff8, 8'h00, 0);
        repeat (2) @(posedge clk);
        rx(13'h1ff9, 8'h04);
        $display("test set_and_freeze done");
        i_rtcm_host.wr(13'h1ff9, 8'h80, 0);
        repeat (40) @(posedge clk);
        rx(13'h1ff9, 8'h80);
        $display("test halt done");
        for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge clk);
        if (exp_q.size() != 0) mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
